// ### design/cdp_consts.svh
// Register map, field positions, reset values and phase codes of the PWM pair block
`ifndef CDP_CONSTS_SVH
`define CDP_CONSTS_SVH

`define CDP_A_DTC     3'h0
`define CDP_A_PCF     3'h1
`define CDP_A_TBC     3'h2
`define CDP_A_OVR     3'h3
`define CDP_A_STS     3'h4

`define CDP_DTC_RST   8'h00
`define CDP_PCF_RST   3'h0
`define CDP_TBC_RST   2'h0
`define CDP_OVR_RST   6'h00
`define CDP_RD_ZERO   8'h00

`define CDP_DT_MSB    5
`define CDP_SEL_MSB   7
`define CDP_SEL_LSB   6
`define CDP_PIS_MSB   2
`define CDP_PSC_MSB   1
`define CDP_OVE_MSB   2
`define CDP_OVV_MSB   5
`define CDP_OVV_LSB   3

`define CDP_PSC_ONE   2'h0
`define CDP_Q1        2'h0
`define CDP_Q_STEP    2'h1
`define CDP_LIM_1     2'h0
`define CDP_LIM_2     2'h1
`define CDP_LIM_4     2'h3

`endif

// ### design/cdp_pkg.sv
// Types shared by the PWM pair block
package cdp_pkg;
  typedef enum logic [1:0] {
    cdp_div2  = 2'h0,
    cdp_div4  = 2'h1,
    cdp_div8  = 2'h2,
    cdp_div16 = 2'h3
  } cdp_dt_sel_t;
  typedef logic [1:0] cdp_qphase_t;
endpackage : cdp_pkg

// ### design/cdp_dt_if.sv
// Signals between the pair controller and one dead-time unit
`timescale 1ns/1ps
`default_nettype none
interface cdp_dt_if;
  logic       src;
  logic       load;
  logic       hit;
  logic [1:0] lim;
  logic       indep;
  logic       upper;
  logic       lower;
  logic       busy;
  modport unit (input src, load, hit, lim, indep, output upper, lower, busy);
  modport ctrl (output src, load, hit, lim, indep, input upper, lower, busy);
endinterface : cdp_dt_if
`default_nettype wire

// ### design/cdp_dead_time_unit.sv
// Dead-time down counter, prescaler and output shaping for one output pair
`timescale 1ns/1ps
`default_nettype none
`include "cdp_consts.svh"
module cdp_dead_time_unit #(
  parameter int DT_W = 6
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  input  wire logic [DT_W-1:0] dt_count,
  input  wire logic            dt_clr,
  cdp_dt_if.unit               pair
);
  logic [DT_W-1:0] cnt_q;
  logic [DT_W-1:0] cnt_d;
  logic [1:0]      psc_q;
  logic [1:0]      psc_d;
  logic            tick;
  logic            up_d;
  logic            lo_d;

  assign pair.busy = (cnt_q != '0);

  always_comb begin
    tick  = pair.hit && (psc_q == pair.lim);
    cnt_d = cnt_q;
    psc_d = psc_q;
    if (pair.load) begin
      cnt_d = dt_count;
      psc_d = 2'h0;
    end else begin
      if (dt_clr) begin
        psc_d = 2'h0;
      end else if (pair.hit) begin
        psc_d = tick ? 2'h0 : psc_q + 2'h1;
      end
      if (tick && cnt_q != '0) begin
        cnt_d = cnt_q - DT_W'(1);
      end
    end
    // Turn-on waits for zero, turn-off follows the source at once
    up_d = pair.indep ? pair.src : (pair.src && cnt_d == '0);
    lo_d = pair.indep ? pair.src : (!pair.src && cnt_d == '0);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q      <= '0;
      psc_q      <= 2'h0;
      pair.upper <= 1'b0;
      pair.lower <= 1'b0;
    end else if (clk_en) begin
      cnt_q      <= cnt_d;
      psc_q      <= psc_d;
      pair.upper <= up_d;
      pair.lower <= lo_d;
    end
  end

  property p_no_overlap;
    @(posedge clk_sys) disable iff (!rst_n)
      !pair.indep |-> !(pair.upper && pair.lower);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair outputs overlap");

  property p_hold_inactive;
    @(posedge clk_sys) disable iff (!rst_n)
      pair.busy && !$past(pair.indep) |-> !pair.upper && !pair.lower;
  endproperty
  a_hold_inactive: assert property (p_hold_inactive) else $error("output on in dead time");

  property p_load;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && pair.load |=> cnt_q == $past(dt_count);
  endproperty
  a_load: assert property (p_load) else $error("edge did not load dead-time count");

  property p_off_now;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && !pair.src && !pair.indep |=> !pair.upper;
  endproperty
  a_off_now: assert property (p_off_now) else $error("upper turn-off delayed");

  property p_zero_dt;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && pair.load && pair.src && dt_count == '0 |=> pair.upper;
  endproperty
  a_zero_dt: assert property (p_zero_dt) else $error("zero dead time delayed upper");

  property p_psc_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && (pair.load || dt_clr) |=> psc_q == 2'h0;
  endproperty
  a_psc_clear: assert property (p_psc_clear) else $error("prescaler not cleared");

  // A reload in the same cycle as a tick takes priority over the step
  property p_span;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && tick && !pair.load && cnt_q != '0 |=> cnt_q == $past(cnt_q) - DT_W'(1);
  endproperty
  a_span: assert property (p_span) else $error("counter did not step on tick");
endmodule : cdp_dead_time_unit
`default_nettype wire

// ### design/cdp_pwm_pairs.sv
// Three complementary PWM output pairs with dead-time insertion and register port
`timescale 1ns/1ps
`default_nettype none
`include "cdp_consts.svh"
module cdp_pwm_pairs #(
  parameter int DT_W = 6
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       duty_compare_a,
  input  wire logic       duty_compare_b,
  input  wire logic       duty_compare_c,
  input  wire logic [1:0] duty_lsb_a,
  input  wire logic [1:0] duty_lsb_b,
  input  wire logic [1:0] duty_lsb_c,
  output logic            upper_drive_a,
  output logic            lower_drive_a,
  output logic            upper_drive_b,
  output logic            lower_drive_b,
  output logic            upper_drive_c,
  output logic            lower_drive_c
);
  localparam int NP = 3;

  logic [7:0]            dtc_q;
  logic [7:0]            dtc_d;
  logic [2:0]            pcf_q;
  logic [2:0]            pcf_d;
  logic [1:0]            tbc_q;
  logic [1:0]            tbc_d;
  logic [5:0]            ovr_q;
  logic [5:0]            ovr_d;
  logic [7:0]            rdata_q;
  logic [7:0]            rdata_d;
  logic [1:0]            q_q;
  logic [1:0]            q_d;
  logic [NP-1:0]         src_q;
  logic [NP-1:0]         src;
  logic [NP-1:0]         cmp;
  logic [NP-1:0]         busy;
  logic [1:0]            lsb [NP];
  logic                  dt_wr;
  logic                  psc_one;
  cdp_pkg::cdp_dt_sel_t  sel;
  logic [DT_W-1:0]       dt_count;

  cdp_dt_if dt_bus[NP] ();

  assign cmp      = {duty_compare_c, duty_compare_b, duty_compare_a};
  assign lsb[0]   = duty_lsb_a;
  assign lsb[1]   = duty_lsb_b;
  assign lsb[2]   = duty_lsb_c;
  assign sel      = cdp_pkg::cdp_dt_sel_t'(dtc_q[`CDP_SEL_MSB:`CDP_SEL_LSB]);
  assign dt_count = dtc_q[DT_W-1:0];
  assign psc_one  = (tbc_q == `CDP_PSC_ONE);
  assign reg_rdata = rdata_q;

  // Register writes and the one-cycle-late read port
  always_comb begin
    dtc_d   = dtc_q;
    pcf_d   = pcf_q;
    tbc_d   = tbc_q;
    ovr_d   = ovr_q;
    rdata_d = `CDP_RD_ZERO;
    dt_wr   = reg_wr && (reg_addr == `CDP_A_DTC);
    if (reg_wr) begin
      case (reg_addr)
        `CDP_A_DTC: dtc_d = reg_wdata;
        `CDP_A_PCF: pcf_d = reg_wdata[`CDP_PIS_MSB:0];
        `CDP_A_TBC: tbc_d = reg_wdata[`CDP_PSC_MSB:0];
        `CDP_A_OVR: ovr_d = reg_wdata[`CDP_OVV_MSB:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `CDP_A_DTC: rdata_d = dtc_q;
        `CDP_A_PCF: rdata_d = {5'h00, pcf_q};
        `CDP_A_TBC: rdata_d = {6'h00, tbc_q};
        `CDP_A_OVR: rdata_d = {2'h0, ovr_q};
        `CDP_A_STS: rdata_d = {2'h0, src_q, busy};
        default:    rdata_d = `CDP_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dtc_q   <= `CDP_DTC_RST;
      pcf_q   <= `CDP_PCF_RST;
      tbc_q   <= `CDP_TBC_RST;
      ovr_q   <= `CDP_OVR_RST;
      rdata_q <= `CDP_RD_ZERO;
    end else if (clk_en) begin
      dtc_q   <= dtc_d;
      pcf_q   <= pcf_d;
      tbc_q   <= tbc_d;
      ovr_q   <= ovr_d;
      rdata_q <= rdata_d;
    end
  end

  // Four instruction phases, one per system clock, phase one after reset
  always_comb begin
    q_d = q_q + `CDP_Q_STEP;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q_q <= `CDP_Q1;
    end else if (clk_en) begin
      q_q <= q_d;
    end
  end

  // Previous source level per pair for edge detection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      src_q <= '0;
    end else if (clk_en) begin
      src_q <= src;
    end
  end

  for (genvar i = 0; i < NP; i++) begin : g_pair
    logic [1:0] m_q;
    logic [1:0] m_d;
    logic [1:0] m_eff;
    logic       hit;
    logic [1:0] lim;

    // Override replaces the compare ahead of the dead-time unit
    assign src[i] = ovr_q[i] ? ovr_q[`CDP_OVV_LSB + i] : cmp[i];

    always_comb begin
      m_d    = m_q;
      if (src[i] != src_q[i]) begin
        m_d = lsb[i];
      end
      m_eff = psc_one ? m_q : `CDP_Q1;
      if (sel == cdp_pkg::cdp_div2) begin
        hit = (q_q[0] == m_eff[0]);
      end else begin
        hit = (q_q == m_eff);
      end
      case (sel)
        cdp_pkg::cdp_div2:  lim = `CDP_LIM_1;
        cdp_pkg::cdp_div4:  lim = `CDP_LIM_1;
        cdp_pkg::cdp_div8:  lim = `CDP_LIM_2;
        default:            lim = `CDP_LIM_4;
      endcase
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        m_q <= `CDP_Q1;
      end else if (clk_en) begin
        m_q <= m_d;
      end
    end

    assign dt_bus[i].src   = src[i];
    assign dt_bus[i].load  = (src[i] != src_q[i]);
    assign dt_bus[i].hit   = hit;
    assign dt_bus[i].lim   = lim;
    assign dt_bus[i].indep = pcf_q[i];
    assign busy[i]         = dt_bus[i].busy;

    cdp_dead_time_unit #(
      .DT_W (DT_W)
    ) u_dt (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .dt_count (dt_count),
      .dt_clr   (dt_wr),
      .pair     (dt_bus[i])
    );

    property p_q1_only;
      @(posedge clk_sys) disable iff (!rst_n)
        hit && !psc_one && sel != cdp_pkg::cdp_div2 |-> q_q == `CDP_Q1;
    endproperty
    a_q1_only: assert property (p_q1_only) else $error("slow tick off phase one");

    // A fresh match-phase capture or a setting change may shift the tick pattern
    property p_two_phase;
      @(posedge clk_sys) disable iff (!rst_n)
        (clk_en && psc_one && sel == cdp_pkg::cdp_div2 && hit) ##1
          (clk_en && $stable(m_q) && $stable(tbc_q) && $stable(sel))
          |-> !hit ##1 (hit || $changed(m_q) || $changed(tbc_q) || $changed(sel));
    endproperty
    a_two_phase: assert property (p_two_phase) else $error("div2 ticks not alternate");

    property p_match_phase;
      @(posedge clk_sys) disable iff (!rst_n)
        hit && psc_one && sel != cdp_pkg::cdp_div2 |-> q_q == m_q;
    endproperty
    a_match_phase: assert property (p_match_phase) else $error("tick not on match phase");

    property p_comp_follow;
      @(posedge clk_sys) disable iff (!rst_n)
        clk_en && !pcf_q[i] |=>
          (!dt_bus[i].upper || $past(src[i])) && (!dt_bus[i].lower || !$past(src[i]));
    endproperty
    a_comp_follow: assert property (p_comp_follow) else $error("output not from compare");

    property p_indep_equal;
      @(posedge clk_sys) disable iff (!rst_n)
        clk_en && pcf_q[i] |=> dt_bus[i].upper == dt_bus[i].lower;
    endproperty
    a_indep_equal: assert property (p_indep_equal) else $error("independent pair differs");

    property p_busy_load;
      @(posedge clk_sys) disable iff (!rst_n)
        clk_en && dt_bus[i].load && dt_count != '0 |=> dt_bus[i].busy;
    endproperty
    a_busy_load: assert property (p_busy_load) else $error("edge did not start dead time");
  end

  assign upper_drive_a = dt_bus[0].upper;
  assign lower_drive_a = dt_bus[0].lower;
  assign upper_drive_b = dt_bus[1].upper;
  assign lower_drive_b = dt_bus[1].lower;
  assign upper_drive_c = dt_bus[2].upper;
  assign lower_drive_c = dt_bus[2].lower;

  property p_reset_comp;
    @(posedge clk_sys) !rst_n |=> pcf_q == `CDP_PCF_RST && dtc_q == `CDP_DTC_RST;
  endproperty
  a_reset_comp: assert property (p_reset_comp) else $error("reset left a pair independent");

  property p_short_duty;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && !pcf_q[0] && dt_bus[0].busy && dt_bus[0].load && !src[0]
        |=> !upper_drive_a;
  endproperty
  a_short_duty: assert property (p_short_duty) else $error("short pulse reached upper");

  property p_read_late;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && reg_rd && reg_addr == `CDP_A_DTC && !reg_wr |=> reg_rdata == $past(dtc_q);
  endproperty
  a_read_late: assert property (p_read_late) else $error("register read data wrong");

  // Read data stand for one cycle only, so a stale word never looks like an answer
  property p_rd_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && !reg_rd |=> reg_rdata == `CDP_RD_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read data");

  property p_rd_unmapped;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && reg_rd && reg_addr > `CDP_A_STS |=> reg_rdata == `CDP_RD_ZERO;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_dtc_write;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == `CDP_A_DTC |=> dtc_q == $past(reg_wdata);
  endproperty
  a_dtc_write: assert property (p_dtc_write) else $error("dead-time write lost");

  property p_pcf_write;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == `CDP_A_PCF |=> pcf_q == $past(reg_wdata[`CDP_PIS_MSB:0]);
  endproperty
  a_pcf_write: assert property (p_pcf_write) else $error("pair mode write lost");

  property p_q_step;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en |=> q_q == $past(q_q) + `CDP_Q_STEP;
  endproperty
  a_q_step: assert property (p_q_step) else $error("phase did not advance");

  // Enable low must freeze phase, settings and edge history alike
  property p_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
      !clk_en |=> $stable(q_q) && $stable(dtc_q) && $stable(src_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule : cdp_pwm_pairs
`default_nettype wire

// ### verification/cdp_hb_switches.sv
// Half-bridge switch model: counts cycles in which both switches of a leg conduct
`timescale 1ns/1ps
`default_nettype none
module cdp_hb_switches (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [2:0]  upper,
  input  wire logic [2:0]  lower,
  output logic      [15:0] shoot_cnt
);
  initial shoot_cnt = 16'h0000;
  // Both switches on shorts the supply rail; an unknown drive counts too unless the other switch of its leg is off
  always @(posedge clk_sys) begin
    if (rst_n && ((upper & lower) !== 3'h0)) begin
      shoot_cnt <= shoot_cnt + 16'h0001;
    end
  end
endmodule : cdp_hb_switches
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the complementary PWM pair block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {int k; int v; int tol;} cdp_note_t;
  logic        clk_sys     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        clk_en      = 1'b1;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic        smp         = 1'b0;
  logic        rd_p        = 1'b0;
  logic [1:0]  up_p        = 2'h0;
  logic [2:0]  reg_addr    = 3'h0;
  logic [2:0]  cmp         = 3'h0;
  logic [5:0]  lsb         = 6'h00;
  logic [7:0]  reg_wdata   = 8'h00;
  logic [15:0] lfsr        = 16'hc30b;
  logic [7:0]  msk[6]      = '{8'hff, 8'h07, 8'h03, 8'h00, 8'h00, 8'h00};
  wire  [7:0]  reg_rdata;
  wire  [5:0]  drv;
  wire  [15:0] shoot_cnt;
  int          miscompares = 0;
  int          checks      = 0;
  int          cyc         = 0;
  int          t0          = 0;
  cdp_note_t   q[$];
  string       nm[4]       = '{"rdata", "drives", "upper_on", "lower_on"};

  cdp_pwm_pairs u_cdp_pwm_pairs (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .clk_en         (clk_en),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .duty_compare_a (cmp[2]),
    .duty_compare_b (cmp[1]),
    .duty_compare_c (cmp[0]),
    .duty_lsb_a     (lsb[5:4]),
    .duty_lsb_b     (lsb[3:2]),
    .duty_lsb_c     (lsb[1:0]),
    .upper_drive_a  (drv[5]),
    .lower_drive_a  (drv[4]),
    .upper_drive_b  (drv[3]),
    .lower_drive_b  (drv[2]),
    .upper_drive_c  (drv[1]),
    .lower_drive_c  (drv[0])
  );

  cdp_hb_switches u_cdp_hb_switches (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .upper     ({drv[5], drv[3], drv[1]}),
    .lower     ({drv[4], drv[2], drv[0]}),
    .shoot_cnt (shoot_cnt)
  );

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // Oldest note against what the outputs show; timing notes carry a tolerance
  task automatic take(input int k, input logic [15:0] got);
    cdp_note_t n;
    n = '{-1, 0, 0};
    if (q.size() > 0) n = q.pop_front();
    checks++;
    if (n.k != k || (k < 2 && got !== n.v[15:0]) ||
        (k > 1 && (int'(got) < n.v - n.tol || int'(got) > n.v + n.tol))) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", nm[k], n.v, got);
    end
  endtask : take

  always @(negedge clk_sys) begin
    if (rd_p) take(0, {8'h00, reg_rdata});
    if (smp) take(1, {shoot_cnt[9:0], drv});
    if (drv[5] === 1'b1 && up_p[1] === 1'b0) take(2, 16'(cyc - t0));
    if (drv[4] === 1'b1 && up_p[0] === 1'b0) take(3, 16'(cyc - t0));
    rd_p = reg_rd & clk_en;
    up_p = drv[5:4];
  end

  task automatic wt(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : wt

  task automatic done(input string s);
    $display("test %s finished, checks %0d", s, checks);
  endtask : done

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    q.push_back('{0, e, 0});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  task automatic look(input logic [5:0] e);
    q.push_back('{1, e, 0});
    smp <= 1'b1;
    @(posedge clk_sys);
    smp <= 1'b0;
    @(posedge clk_sys);
  endtask : look

  // Pair a source edge; the turn-on side must wait count times prescaled period
  task automatic edge_a(input logic v, input int n, input int p);
    q.push_back('{v ? 2 : 3, n * p, p + 3});
    cmp[2] <= v;
    t0 = cyc;
    wt(3 * n * p + p + 8);
  endtask : edge_a

  initial begin
    int n;
    int p;
    q.push_back('{3, 0, 9999});
    wt(3);
    rst_n <= 1'b1;
    wt(2);
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    look(6'h15);
    done("reset values");
    // Override register is left out here: it would launch dead-time edges
    for (int a = 0; a < 6; a++) begin
      if (a == 3) continue;
      wr(a[2:0], 8'hff);
      rd(a[2:0], msk[a]);
      // Leaving independent mode turns lower a back on two cycles later
      if (a == 1) begin
        q.push_back('{3, 2, 1});
        t0 = cyc;
      end
      wr(a[2:0], 8'h00);
    end
    clk_en <= 1'b0;
    wr(3'h0, 8'h3f);
    clk_en <= 1'b1;
    rd(3'h0, 8'h00);
    done("registers");
    for (int t = 0; t < 4; t++) begin
      for (int s = 0; s < 4; s++) begin
        lfsr = nxt(lfsr);
        n = 8 + int'(lfsr[3:0]);
        p = 2 << s;
        lsb[5:4] <= lfsr[5:4];
        wr(3'h2, {6'h00, t[1:0]});
        wr(3'h0, {s[1:0], n[5:0]});
        edge_a(1'b1, n, p);
        edge_a(1'b0, n, p);
      end
    end
    done("dead time");
    wr(3'h0, 8'h00);
    edge_a(1'b1, 0, 2);
    edge_a(1'b0, 0, 2);
    wr(3'h0, 8'h14);
    cmp[2] <= 1'b1;
    wt(10);
    q.push_back('{3, 40, 5});
    cmp[2] <= 1'b0;
    t0 = cyc;
    wt(60);
    done("zero and short");
    lsb[3:0] <= lfsr[9:6];
    cmp[1:0] <= 2'h2;
    wt(100);
    look(6'h19);
    cmp[1:0] <= 2'h0;
    wr(3'h1, 8'h02);
    wt(100);
    look(6'h11);
    wr(3'h1, 8'h00);
    wt(100);
    look(6'h15);
    done("pairs");
    wr(3'h0, 8'h4a);
    q.push_back('{2, 40, 9});
    t0 = cyc;
    wr(3'h3, 8'h09);
    wt(150);
    rd(3'h3, 8'h09);
    rd(3'h4, 8'h08);
    q.push_back('{3, 40, 9});
    t0 = cyc;
    wr(3'h3, 8'h00);
    wt(150);
    done("override");
    wr(3'h1, 8'h07);
    q.push_back('{3, 0, 9999});
    rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    wt(5);
    rd(3'h1, 8'h00);
    look(6'h15);
    done("second reset");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
